// *** rtl/ccd_core.sv ***
`timescale 1ns/1ps
// software issues one instruction per write to the instruction register;
// the block decodes it, updates flags, pc, sp, a 16-entry working register
// file, and reports the pushed pc word. one write / one read at a time.
module ccd_core (
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write address
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [3:0]  s_axi_awaddr,
   // axi4-lite write data
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   // axi4-lite write response
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   // axi4-lite read address
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [3:0]  s_axi_araddr,
   // axi4-lite read data
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   // decode results
   output logic             cond_true,
   output logic [15:0]      push_word
);
   import ccd_pkg::*;

   // condition evaluation from the four flags
   function automatic logic eval_cond(input logic [3:0] cc,
                                      input logic [7:0] f);
      logic c;
      logic z;
      logic s;
      logic v;
      c = f[FL_C];
      z = f[FL_Z];
      s = f[FL_S];
      v = f[FL_V];
      case (cc)
         CC_NEVER:                     eval_cond = 1'b0;
         CC_ALWAYS:                    eval_cond = 1'b1;
         CC_C:                         eval_cond = c;
         CC_NC:                        eval_cond = ~c;
         CC_UNSIGNED_LE_COND:          eval_cond = c | z;
         CC_UNSIGNED_GT_COND:          eval_cond = ~c & ~z;
         CC_SIGNED_GREATER_EQUAL_COND: eval_cond = ~(s ^ v);
         CC_SIGNED_BELOW_COND:         eval_cond = s ^ v;
         CC_SIGNED_ABOVE_COND:         eval_cond = ~(z | (s ^ v));
         CC_SIGNED_AT_MOST_COND:       eval_cond = z | (s ^ v);
         CC_Z:                         eval_cond = z;
         CC_NZ:                        eval_cond = ~z;
         CC_MI:                        eval_cond = s;
         CC_PL:                        eval_cond = ~s;
         CC_OV:                        eval_cond = v;
         CC_NOV:                       eval_cond = ~v;
         default:                      eval_cond = 1'b0;
      endcase
   endfunction

   // axi slave state
   logic        aw_held;
   logic [3:0]  aw_addr;
   logic        w_held;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        next_aw_held;
   logic [3:0]  next_aw_addr;
   logic        next_w_held;
   logic [31:0] next_w_data;
   logic [3:0]  next_w_strb;
   logic        next_bvalid;
   logic [1:0]  next_bresp;
   logic        next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0]  next_rresp;
   logic        next_awready;
   logic        next_wready;
   logic        next_arready;
   logic        do_write;

   // block state
   logic [7:0]  flags;
   logic [7:0]  result;
   logic [15:0] pc;
   logic [15:0] sp;
   logic [3:0]  cond_sel;
   logic [7:0]  rel_off;
   logic [7:0]  wreg [16];
   logic [7:0]  next_flags;
   logic [7:0]  next_result;
   logic [15:0] next_pc;
   logic [15:0] next_sp;
   logic [3:0]  next_cond_sel;
   logic [7:0]  next_rel_off;
   logic        next_cond_true;
   logic [15:0] next_push_word;
   logic        wreg_we;
   logic [3:0]  wreg_idx;
   logic [7:0]  wreg_val;
   ccd_kind_e   kind;

   // write fires once both address and data are in hand and b is free
   assign do_write = aw_held & w_held & ~s_axi_bvalid;

   // axi channel bookkeeping
   always_comb begin
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held  = w_held;
      next_w_data  = w_data;
      next_w_strb  = w_strb;
      next_bvalid  = s_axi_bvalid;
      next_bresp   = s_axi_bresp;
      next_rvalid  = s_axi_rvalid;
      next_rdata   = s_axi_rdata;
      next_rresp   = s_axi_rresp;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = (aw_addr == A_INSTR || aw_addr == A_CTRL) ?
                        RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_rvalid = 1'b1;
         next_rresp  = RESP_OKAY;
         case (s_axi_araddr)
            A_STAT:  next_rdata = {16'h0000, result, flags};
            A_PCSP:  next_rdata = {sp, pc};
            A_CTRL:  next_rdata = {16'h0000, rel_off, 4'h0, cond_sel};
            default: begin
               next_rdata = 32'h00000000;
               next_rresp = RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      // ready only while the holding slot is free; it drops on the edge an
      // item is taken so a held slot is never overwritten, at the cost of
      // one idle cycle between back-to-back items
      next_awready = ~next_aw_held & ~(s_axi_awvalid & s_axi_awready);
      next_wready  = ~next_w_held & ~(s_axi_wvalid & s_axi_wready);
      next_arready = ~next_rvalid & ~(s_axi_arvalid & s_axi_arready);
   end

   // instruction decode and execute
   always_comb begin
      logic [8:0] sum;
      logic [4:0] hsum;
      logic [7:0] dst;
      logic [7:0] src;
      logic [7:0] op;
      logic [7:0] dec;
      logic       cin;
      sum            = 9'h000;
      hsum           = 5'h00;
      dec            = 8'h00;
      cin            = 1'b0;
      op             = w_data[7:0];
      dst            = w_data[15:8];
      src            = w_data[23:16];
      kind           = OPK_NONE;
      next_flags     = flags;
      next_result    = result;
      next_pc        = pc;
      next_sp        = sp;
      next_cond_sel  = cond_sel;
      next_rel_off   = rel_off;
      next_push_word = push_word;
      wreg_we        = 1'b0;
      wreg_idx       = op[7:4];
      wreg_val       = 8'h00;
      next_cond_true = eval_cond(cond_sel, flags);
      if (do_write && aw_addr == A_CTRL) begin
         if (w_strb[0]) begin
            next_cond_sel = w_data[3:0];
         end
         if (w_strb[1]) begin
            next_rel_off = w_data[15:8];
         end
      end
      if (do_write && aw_addr == A_INSTR && w_strb[0]) begin
         if (op[7:4] == OP_ADD_HI || op[7:4] == OP_ADC_HI) begin
            kind = OPK_ALU;
            cin  = (op[7:4] == OP_ADC_HI) & flags[FL_C];
            sum  = {1'b0, dst} + {1'b0, src} + {8'h00, cin};
            hsum = {1'b0, dst[3:0]} + {1'b0, src[3:0]} + {4'h0, cin};
            next_result       = sum[7:0];
            next_flags[FL_C]  = sum[8];
            next_flags[FL_Z]  = (sum[7:0] == 8'h00);
            next_flags[FL_S]  = sum[7];
            next_flags[FL_V]  = (dst[7] == src[7]) && (sum[7] != dst[7]);
            next_flags[FL_D]  = 1'b0;
            next_flags[FL_H]  = hsum[4];
         end else if (op[7:4] == OP_AND_HI) begin
            kind = OPK_ALU;
            next_result      = dst & src;
            next_flags[FL_Z] = ((dst & src) == 8'h00);
            next_flags[FL_S] = dst[7] & src[7];
            next_flags[FL_V] = 1'b0;
         end else if (op == OP_CALL_DIRECT_TARGET || op == OP_CALL_IRR) begin
            kind = OPK_CALL;
            next_sp        = sp - SP_CALL_STEP;
            next_push_word = pc;
            // direct takes the immediate word, indirect a register pair
            next_pc = (op == OP_CALL_DIRECT_TARGET) ? {dst, src} :
                      {wreg[{dst[3:1], 1'b0}], wreg[{dst[3:1], 1'b1}]};
         end else if (op[3:0] == OP_DECREMENT_BRANCH_LO) begin
            kind     = OPK_DECREMENT_BRANCH;
            dec      = wreg[op[7:4]] - 8'h01;
            wreg_we  = 1'b1;
            wreg_val = dec;
            next_result = dec;
            // signed offset, sign-extended; flags stay put
            if (dec != 8'h00) begin
               next_pc = pc + {{8{dst[7]}}, dst};
            end
         end
         if (kind == OPK_ALU && op[3:0] == 4'h2) begin
            // register-register form writes back to the working file
            wreg_we  = 1'b1;
            wreg_idx = dst[3:0];
            wreg_val = next_result;
         end
      end
   end

   // register everything
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held       <= 1'b0;
         aw_addr       <= 4'h0;
         w_held        <= 1'b0;
         w_data        <= 32'h00000000;
         w_strb        <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_arready <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= RESP_OKAY;
         flags         <= FLAGS_RST;
         result        <= 8'h00;
         pc            <= PC_RST;
         sp            <= SP_RST;
         cond_sel      <= CC_NEVER;
         rel_off       <= 8'h00;
         cond_true     <= 1'b0;
         push_word     <= 16'h0000;
         for (int i = 0; i < 16; i++) begin
            wreg[i] <= 8'h00;
         end
      end else begin
         aw_held       <= next_aw_held;
         aw_addr       <= next_aw_addr;
         w_held        <= next_w_held;
         w_data        <= next_w_data;
         w_strb        <= next_w_strb;
         s_axi_awready <= next_awready;
         s_axi_wready  <= next_wready;
         s_axi_arready <= next_arready;
         s_axi_bvalid  <= next_bvalid;
         s_axi_bresp   <= next_bresp;
         s_axi_rvalid  <= next_rvalid;
         s_axi_rdata   <= next_rdata;
         s_axi_rresp   <= next_rresp;
         flags         <= next_flags;
         result        <= next_result;
         pc            <= next_pc;
         sp            <= next_sp;
         cond_sel      <= next_cond_sel;
         rel_off       <= next_rel_off;
         cond_true     <= next_cond_true;
         push_word     <= next_push_word;
         if (wreg_we) begin
            wreg[wreg_idx] <= wreg_val;
         end
      end
   end
endmodule

// *** rtl/ccd_pkg.sv ***
// Summary of operation
// - code 1111 true when carry clear; code 0111 true when carry set
// - code 0011 true when carry or zero is set
// - code 1011 true only when carry and zero are both clear
// - code 1001 true when sign xor overflow is 0; 0001 when 1
// - code 1010 true when zero or (sign xor overflow) is 0; 0010 when 1
// - add-with-carry 1x: dst+src+carry, sets C Z S V H, clears D
// - add 0x: dst+src, sets C Z S V H, clears D
// - and 5x: dst and src, sets Z S, clears V, keeps C D H
// - call D6/D4: stack pointer minus 2, push pc, jump; flags kept
// - decrement-branch rA: decrement r, add signed offset if nonzero
package ccd_pkg;
   // condition codes
   localparam logic [3:0] CC_NEVER                     = 4'h0;
   localparam logic [3:0] CC_SIGNED_BELOW_COND         = 4'h1;
   localparam logic [3:0] CC_SIGNED_AT_MOST_COND       = 4'h2;
   localparam logic [3:0] CC_UNSIGNED_LE_COND          = 4'h3;
   localparam logic [3:0] CC_OV                        = 4'h4;
   localparam logic [3:0] CC_MI                        = 4'h5;
   localparam logic [3:0] CC_Z                         = 4'h6;
   localparam logic [3:0] CC_C                         = 4'h7;
   localparam logic [3:0] CC_ALWAYS                    = 4'h8;
   localparam logic [3:0] CC_SIGNED_GREATER_EQUAL_COND = 4'h9;
   localparam logic [3:0] CC_SIGNED_ABOVE_COND         = 4'hA;
   localparam logic [3:0] CC_UNSIGNED_GT_COND          = 4'hB;
   localparam logic [3:0] CC_NOV                       = 4'hC;
   localparam logic [3:0] CC_PL                        = 4'hD;
   localparam logic [3:0] CC_NZ                        = 4'hE;
   localparam logic [3:0] CC_NC                        = 4'hF;
   // opcode high nibbles, a low nibble and full opcodes
   localparam logic [3:0] OP_ADD_HI              = 4'h0;
   localparam logic [3:0] OP_ADC_HI              = 4'h1;
   localparam logic [3:0] OP_AND_HI              = 4'h5;
   localparam logic [3:0] OP_DECREMENT_BRANCH_LO = 4'hA;
   localparam logic [7:0] OP_CALL_DIRECT_TARGET  = 8'hD6;
   localparam logic [7:0] OP_CALL_IRR            = 8'hD4;
   // flag bit positions in the flags byte
   localparam int FL_C = 7;
   localparam int FL_Z = 6;
   localparam int FL_S = 5;
   localparam int FL_V = 4;
   localparam int FL_D = 3;
   localparam int FL_H = 2;
   // axi register offsets
   localparam logic [3:0] A_INSTR = 4'h0; // w: [7:0] op [15:8] dst [23:16] src
   localparam logic [3:0] A_CTRL  = 4'h4; // rw: [3:0] cond, [15:8] offset
   localparam logic [3:0] A_STAT  = 4'h8; // r: [7:0] flags [15:8] result
   localparam logic [3:0] A_PCSP  = 4'hC; // r: [15:0] pc  [31:16] sp
   localparam logic [7:0]  FLAGS_RST = 8'h00;
   localparam logic [15:0] PC_RST    = 16'h000C;
   localparam logic [15:0] SP_RST    = 16'h0000;
   localparam logic [15:0] SP_CALL_STEP = 16'h0002;
   localparam logic [1:0]  RESP_OKAY   = 2'b00;
   localparam logic [1:0]  RESP_SLVERR = 2'b10;
   typedef enum logic [1:0] {
      OPK_NONE, OPK_ALU, OPK_CALL, OPK_DECREMENT_BRANCH
   } ccd_kind_e;
endpackage

// *** sim/ccd_core_chk.sv ***
`timescale 1ns/1ps
// bus handshake and update timing, seen from the core's ports only
module ccd_chk
   import ccd_pkg::*;
(
   // clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // write channels
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [3:0]  s_axi_awaddr,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   // read channels
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [3:0]  s_axi_araddr,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   // decode result
   input wire logic        cond_true
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic       whs;
   logic       rhs;
   logic [2:0] quiet;
   logic [2:0] next_quiet;
   // both write halves taken on one edge; the bench offers them together
   assign whs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   assign rhs = s_axi_arvalid && s_axi_arready;
   // cycles since a write response, saturating so it never wraps to zero
   always_comb begin
      next_quiet = quiet;
      if (s_axi_bvalid)
         next_quiet = 3'h0;
      else if (quiet != 3'h7)
         next_quiet = quiet + 3'h1;
   end
   always_ff @(posedge aclk) begin
      quiet <= aresetn ? next_quiet : 3'h7;
   end
   property p_bhold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("bvalid dropped early");
   property p_rhold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read data not held");
   property p_wlat;
      whs |-> ##[2:3] s_axi_bvalid;
   endproperty
   a_wlat: assert property (p_wlat) else $error("write answer late");
   property p_rlat;
      rhs |=> s_axi_rvalid;
   endproperty
   a_rlat: assert property (p_rlat) else $error("read answer late");
   property p_arblk;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_arblk: assert property (p_arblk) else $error("read taken while busy");
   property p_unmap;
      whs && s_axi_awaddr == A_STAT |-> ##[2:3] s_axi_bresp == RESP_SLVERR;
   endproperty
   a_unmap: assert property (p_unmap) else $error("write to status accepted");
   property p_rd0;
      rhs && s_axi_araddr == A_INSTR |=> s_axi_rresp == RESP_SLVERR
         && s_axi_rdata == 32'h0000_0000;
   endproperty
   a_rd0: assert property (p_rd0) else $error("instr read not refused");
   property p_cond;
      $changed(cond_true) |-> quiet < 3'h4;
   endproperty
   a_cond: assert property (p_cond) else $error("cond moved alone");
   // a fixed code selected by a write shows on cond_true three edges later,
   // whatever the flags hold at that time
   property p_never;
      whs && s_axi_awaddr == A_CTRL && s_axi_wstrb[0]
         && s_axi_wdata[3:0] == CC_NEVER |-> ##3 !cond_true;
   endproperty
   a_never: assert property (p_never)
      else $error("never code true");
   property p_always;
      whs && s_axi_awaddr == A_CTRL && s_axi_wstrb[0]
         && s_axi_wdata[3:0] == CC_ALWAYS |-> ##3 cond_true;
   endproperty
   a_always: assert property (p_always)
      else $error("always code false");
endmodule

bind ccd_core ccd_chk u_ccd_chk (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
   .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
   .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
   .s_axi_rresp, .cond_true);

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
   import ccd_pkg::*;
   logic        aclk, rstn, awv, wv, bv, br, arv, rv, rr, awr, wrd, arr, ct;
   logic [3:0]  awa, ara, wst;
   logic [31:0] wd, rd, v;
   logic [1:0]  bre, rre, r;
   logic [15:0] pw, e;
   logic [7:0]  fl, op, d, s;
   int          errors, comparisons;
   ccd_core u_ccd_core (.aclk(aclk), .aresetn(rstn), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
      .s_axi_wready(wrd), .s_axi_wdata(wd), .s_axi_wstrb(wst),
      .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bre),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
      .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd),
      .s_axi_rresp(rre), .cond_true(ct), .push_word(pw));
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   task automatic chk(input string n, input logic [31:0] x,
                      input logic [31:0] g);
      comparisons++;
      if (g !== x) begin
         errors++;
         $display("MISMATCH %s exp %h got %h", n, x, g);
      end
   endtask
   // address and data may be taken on different edges, so track each half
   task automatic wr(input logic [3:0] a, input logic [31:0] x);
      logic ad, dd;
      ad = 1'b0;
      dd = 1'b0;
      @(posedge aclk);
      awv <= 1'b1;
      awa <= a;
      wv <= 1'b1;
      wd <= x;
      br <= 1'b1;
      while (!(ad && dd)) begin
         @(posedge aclk);
         if (awr && !ad)
            awv <= 1'b0;
         if (wrd && !dd)
            wv <= 1'b0;
         ad = ad | awr;
         dd = dd | wrd;
      end
      do @(posedge aclk); while (!bv);
      r = bre;
      br <= 1'b0;
   endtask
   task automatic rdr(input logic [3:0] a);
      @(posedge aclk);
      arv <= 1'b1;
      ara <= a;
      rr <= 1'b1;
      do @(posedge aclk); while (!arr);
      arv <= 1'b0;
      do @(posedge aclk); while (!rv);
      v = rd;
      r = rre;
      rr <= 1'b0;
   endtask
   task automatic ex(input logic [7:0] o, input logic [7:0] x,
                     input logic [7:0] y);
      wr(A_INSTR, {8'h00, y, x, o});
      chk("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
   endtask
   // expected {result, flags} after an add, add-with-carry or and
   function automatic logic [15:0] alu(input logic [7:0] o, x, y, f);
      logic [8:0] t;
      logic [4:0] h;
      logic [7:0] n;
      n = f;
      t = {1'b0, x} + {1'b0, y} + {8'h00, o[4] & f[FL_C]};
      h = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, o[4] & f[FL_C]};
      n[FL_C] = t[8];
      n[FL_V] = (x[7] == y[7]) && (t[7] != x[7]);
      n[FL_D] = 1'b0;
      n[FL_H] = h[4];
      if (o[7:4] == OP_AND_HI) begin
         t = {1'b0, x & y};
         n = f;
         n[FL_V] = 1'b0;
      end
      n[FL_Z] = t[7:0] == 8'h00;
      n[FL_S] = t[7];
      return {t[7:0], n};
   endfunction
   function automatic logic ce(input logic [3:0] c, input logic [7:0] f);
      logic [7:0] b;
      b = {f[FL_C], f[FL_Z], f[FL_S], f[FL_V], f[FL_C] | f[FL_Z],
           f[FL_Z] | (f[FL_S] ^ f[FL_V]), f[FL_S] ^ f[FL_V], 1'b0};
      return b[c[2:0]] ^ c[3];
   endfunction
   // every code against the current flags; cond lags the write by one cycle
   task automatic sweep();
      logic [31:0] x;
      logic [31:0] g;
      for (int c = 0; c < 16; c++) begin
         wr(A_CTRL, 32'(c));
         repeat (2) @(posedge aclk);
         x = {31'h0, ce(4'(c), fl)};
         g = {31'h0, ct};
         case (c[2:0])
            3'h0:       chk("cond", x, g);
            3'h7:       chk("cond", x, g);
            3'h3:       chk("cond", x, g);
            3'h1, 3'h2: chk("cond", x, g);
            default:    chk("cond", x, g);
         endcase
      end
   endtask
   task automatic end_of_test();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #1500000;
      errors++;
      $display("watchdog expired");
      end_of_test();
   end
   initial begin
      {rstn, awv, wv, br, arv, rr, awa, ara, wd} = '0;
      wst = 4'hF;
      fl = FLAGS_RST;
      void'($urandom(32'hB37FBC55));
      repeat (4) @(posedge aclk);
      rstn <= 1'b1;
      repeat (2) @(posedge aclk);
      rdr(A_PCSP);
      chk("pcsp", {SP_RST, PC_RST}, v);
      // two calls back to back, then branches at both offset extremes
      ex(OP_CALL_DIRECT_TARGET, 8'h12, 8'h34);
      rdr(A_PCSP);
      chk("pcsp", {16'hFFFE, 16'h1234}, v);
      chk("push", {16'h0, PC_RST}, {16'h0, pw});
      ex(OP_CALL_IRR, 8'h00, 8'h00);
      rdr(A_PCSP);
      chk("pcsp", {16'hFFFC, 16'h0000}, v);
      chk("push", 32'h0000_1234, {16'h0, pw});
      ex(8'h4A, 8'h80, 8'h00);
      ex(8'h4A, 8'h7F, 8'h00);
      rdr(A_PCSP);
      chk("pcsp", {16'hFFFC, 16'hFFFF}, v);
      e = alu(8'h02, 8'h03, 8'hFE, fl);
      fl = e[7:0];
      ex(8'h02, 8'h03, 8'hFE);
      ex(8'h3A, 8'h10, 8'h00);
      rdr(A_PCSP);
      chk("pcsp", {16'hFFFC, 16'hFFFF}, v);
      rdr(A_STAT);
      chk("flags", {24'h0, fl}, {24'h0, v[7:0]});
      $display("flow test done");
      wr(A_STAT, 32'h0000_00FF);
      chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
      rdr(A_INSTR);
      chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
      $display("bus test done");
      // operand corners first, then random operands; opcodes cycle add, add-with-carry, and
      for (int i = 0; i < 20; i++) begin
         op[7:4] = (i % 3 == 2) ? OP_AND_HI : 4'(i % 3);
         op[3:0] = 4'($urandom_range(0, 1));
         d = i < 4 ? 8'h7F << (i % 2) : 8'($urandom);
         s = i < 4 ? 8'h01 << (i * 2) : 8'($urandom);
         e = alu(op, d, s, fl);
         fl = e[7:0];
         ex(op, d, s);
         rdr(A_STAT);
         chk("stat", {16'h0, e}, v);
         sweep();
      end
      rdr(A_CTRL);
      chk("ctrl", 32'hF, {28'h0, v[3:0]});
      $display("alu and condition test done");
      end_of_test();
   end
endmodule
